// ==== verilog/ssrs_pkg.sv ====
// Constants of the supply reset supervisor
// Operation
// - Hold reset while supply is low, then for the timeout after recovery.
// - After the timeout, stop driving the open-drain reset pin.
// - Assert reset within 5 us of the supply falling below threshold.
// - Ignore supply dips of up to 30 ns; they start no reset.
// - A filtered falling edge on the reset pin restarts the timeout.
// - A manual reset keeps reset active for the full timeout.
// - Manual-reset pulses shorter than 100 ns are filtered out.
// - During reset, abort bus transactions and refuse new ones.
// - During reset start no write; a running write cycle completes.
// - After a write STOP, run a write cycle of at most 5 ms, bus off.
// - SDA change while SCL high is a START or a STOP.
// - START is SDA falling with SCL high; nothing counts before it.
// - STOP is SDA rising with SCL high; every operation ends with it.
package ssrs_pkg;
    localparam int CLK_PERIOD_PS = 4000;
    localparam int RESET_TIMEOUT_MS = 200;
    localparam int TRIP_TO_OUTPUT_DELAY_US = 5;
    localparam int SUPPLY_GLITCH_REJECT_WIDTH_NS = 30;
    localparam int MANUAL_RESET_GLITCH_NS = 100;
    localparam int INTERNAL_PROGRAM_TIME_MS = 5;
    localparam int POWERUP_READ_WAIT_MS = 270;
    localparam int POWERUP_WRITE_WAIT_MS = 270;
    // Kept apart so the millisecond products stay inside 32 bits
    localparam int CYCLES_PER_MS = 1000000000 / CLK_PERIOD_PS;
    localparam int RESET_TIMEOUT_CYCLES = RESET_TIMEOUT_MS * CYCLES_PER_MS;
    // Longest time rounds down
    localparam int TRIP_DELAY_CYCLES = TRIP_TO_OUTPUT_DELAY_US * 1000000 / CLK_PERIOD_PS;
    // Least rejection widths round up
    localparam int SUPPLY_GLITCH_CYCLES =
        (SUPPLY_GLITCH_REJECT_WIDTH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int MANUAL_GLITCH_CYCLES =
        (MANUAL_RESET_GLITCH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int PROGRAM_CYCLES = INTERNAL_PROGRAM_TIME_MS * CYCLES_PER_MS;
    localparam int TIMER_WIDTH = 26;
    localparam int FILTER_WIDTH = 8;
    localparam logic RESET_OUT_ACTIVE_INIT = 1'b1;
endpackage : ssrs_pkg

// ==== verilog/ssrs_filter_if.sv ====
// Interface carrying a filtered level and its edge strobes
`timescale 1ns/1ps
interface ssrs_filter_if;
    logic level;
    logic fall;
    logic rise;
    modport source (output level, output fall, output rise);
    modport sink (input level, input fall, input rise);
endinterface : ssrs_filter_if

// ==== verilog/ssrs_glitch_filter.sv ====
// Synchronising glitch filter with edge strobes
`timescale 1ns/1ps
module ssrs_glitch_filter
    import ssrs_pkg::*;
#(
    parameter int STABLE_CYCLES = 1,
    parameter logic INIT = 1'b1
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic raw,
    ssrs_filter_if.source out
);
    if (STABLE_CYCLES < 1 || STABLE_CYCLES >= (1 << FILTER_WIDTH))
    begin : g_bad_stable
        $error("ssrs_glitch_filter: STABLE_CYCLES out of range");
    end

    typedef struct packed {
        logic sync1;
        logic sync2;
        logic level;
        logic fall;
        logic rise;
        logic [FILTER_WIDTH-1:0] count;
    } ssrs_filt_state_type;

    ssrs_filt_state_type state;
    ssrs_filt_state_type next_state;

    always_comb
    begin
        next_state = state;
        next_state.sync1 = raw;
        next_state.sync2 = state.sync1;
        next_state.fall = 1'b0;
        next_state.rise = 1'b0;
        if (state.sync2 == state.level)
            next_state.count = '0;
        else if (state.count == FILTER_WIDTH'(STABLE_CYCLES - 1))
        begin
            next_state.count = '0;
            next_state.level = state.sync2;
            next_state.fall = ~state.sync2;
            next_state.rise = state.sync2;
        end
        else
            next_state.count = state.count + 1'b1;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            state <= '{sync1: INIT, sync2: INIT, level: INIT, fall: 1'b0, rise: 1'b0,
                count: '0};
        else
            state <= next_state;
    end

    assign out.level = state.level;
    assign out.fall = state.fall;
    assign out.rise = state.rise;
endmodule : ssrs_glitch_filter

// ==== verilog/ssrs_supervisor.sv ====
// Supply reset supervisor with bus guard and write-cycle timer
`timescale 1ns/1ps
module ssrs_supervisor
    import ssrs_pkg::*;
#(
    parameter int TIMEOUT_CYCLES = RESET_TIMEOUT_CYCLES,
    parameter int PROG_CYCLES = PROGRAM_CYCLES,
    parameter int SUPPLY_FILTER_CYCLES = SUPPLY_GLITCH_CYCLES + 1,
    parameter int MANUAL_FILTER_CYCLES = MANUAL_GLITCH_CYCLES + 1
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic supply_low,
    input wire logic reset_pin_in,
    output logic reset_pin_out,
    output logic reset_pin_oe_n,
    output logic reset_active,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic write_request,
    output logic bus_enabled,
    output logic transaction_open,
    output logic transaction_abort,
    output logic program_busy,
    output logic program_start
);
    if (TIMEOUT_CYCLES < 2 || TIMEOUT_CYCLES >= (1 << TIMER_WIDTH))
    begin : g_bad_timeout
        $error("ssrs_supervisor: TIMEOUT_CYCLES out of range");
    end
    if (PROG_CYCLES < 2 || PROG_CYCLES >= (1 << TIMER_WIDTH))
    begin : g_bad_prog
        $error("ssrs_supervisor: PROG_CYCLES out of range");
    end
    if (SUPPLY_FILTER_CYCLES > TRIP_DELAY_CYCLES)
    begin : g_bad_filter
        $error("ssrs_supervisor: supply filter slower than trip delay");
    end

    typedef enum {SSRS_RST_HOLD, SSRS_RST_TIMING, SSRS_RST_RELEASED} ssrs_rst_type;
    typedef enum {SSRS_BUS_IDLE, SSRS_BUS_ACTIVE} ssrs_bus_type;

    typedef struct packed {
        ssrs_rst_type rst;
        ssrs_bus_type bus;
        logic [TIMER_WIDTH-1:0] timer;
        logic [TIMER_WIDTH-1:0] prog_timer;
        logic pin_drive;
        logic pin_oe_n;
        logic active;
        logic open;
        logic abort;
        logic busy;
        logic start;
        logic enabled;
        logic write_pending;
        logic scl_s1;
        logic scl_s2;
        logic sda_s1;
        logic sda_s2;
        logic sda_prev;
    } ssrs_state_type;

    ssrs_state_type state;
    ssrs_state_type next_state;

    ssrs_filter_if supply_f ();
    ssrs_filter_if manual_f ();

    // Supply indication filtered against short dips
    ssrs_glitch_filter #(
        .STABLE_CYCLES(SUPPLY_FILTER_CYCLES),
        .INIT(1'b1)
    ) u_supply_filter (
        .clk(clk),
        .rst_n(rst_n),
        .raw(supply_low),
        .out(supply_f.source)
    );

    // Manual reset pin filtered against short pulses
    ssrs_glitch_filter #(
        .STABLE_CYCLES(MANUAL_FILTER_CYCLES),
        .INIT(1'b1)
    ) u_manual_filter (
        .clk(clk),
        .rst_n(rst_n),
        .raw(reset_pin_in),
        .out(manual_f.source)
    );

    logic start_cond;
    logic stop_cond;
    logic hold;

    always_comb
    begin
        start_cond = state.scl_s2 && state.sda_prev && !state.sda_s2;
        stop_cond = state.scl_s2 && !state.sda_prev && state.sda_s2;
        // Own drive is excluded so only an outside falling edge retriggers
        hold = supply_f.level || (manual_f.fall && !state.pin_drive);

        next_state = state;
        next_state.scl_s1 = scl_in;
        next_state.scl_s2 = state.scl_s1;
        next_state.sda_s1 = sda_in;
        next_state.sda_s2 = state.sda_s1;
        next_state.sda_prev = state.sda_s2;
        next_state.abort = 1'b0;
        next_state.start = 1'b0;

        case (state.rst)
            SSRS_RST_HOLD:
            begin
                next_state.timer = '0;
                if (!supply_f.level)
                    next_state.rst = SSRS_RST_TIMING;
            end
            SSRS_RST_TIMING:
            begin
                if (supply_f.level)
                    next_state.rst = SSRS_RST_HOLD;
                else if (state.timer == TIMER_WIDTH'(TIMEOUT_CYCLES - 1))
                    next_state.rst = SSRS_RST_RELEASED;
                else
                    next_state.timer = state.timer + 1'b1;
            end
            SSRS_RST_RELEASED:
            begin
                next_state.timer = '0;
                if (supply_f.level)
                    next_state.rst = SSRS_RST_HOLD;
                else if (hold)
                    next_state.rst = SSRS_RST_TIMING;
            end
            default:
                next_state.rst = SSRS_RST_HOLD;
        endcase

        next_state.active = (next_state.rst != SSRS_RST_RELEASED);
        next_state.pin_drive = next_state.active;
        next_state.pin_oe_n = !next_state.active;

        if (state.busy)
        begin
            // A running write finishes whatever reset does
            if (state.prog_timer == TIMER_WIDTH'(PROG_CYCLES - 1))
            begin
                next_state.busy = 1'b0;
                next_state.prog_timer = '0;
            end
            else
                next_state.prog_timer = state.prog_timer + 1'b1;
        end

        case (state.bus)
            SSRS_BUS_IDLE:
            begin
                next_state.write_pending = 1'b0;
                if (start_cond && !state.active && !state.busy)
                begin
                    next_state.bus = SSRS_BUS_ACTIVE;
                end
            end
            SSRS_BUS_ACTIVE:
            begin
                if (write_request)
                    next_state.write_pending = 1'b1;
                if (state.active)
                begin
                    next_state.bus = SSRS_BUS_IDLE;
                    next_state.abort = 1'b1;
                    next_state.write_pending = 1'b0;
                end
                else if (stop_cond)
                begin
                    next_state.bus = SSRS_BUS_IDLE;
                    if (state.write_pending || write_request)
                    begin
                        next_state.busy = 1'b1;
                        next_state.start = 1'b1;
                        next_state.prog_timer = '0;
                    end
                end
            end
            default:
                next_state.bus = SSRS_BUS_IDLE;
        endcase

        next_state.open = (next_state.bus == SSRS_BUS_ACTIVE);
        next_state.enabled = !next_state.active && !next_state.busy;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= '0;
            state.rst <= SSRS_RST_HOLD;
            state.bus <= SSRS_BUS_IDLE;
            state.pin_drive <= RESET_OUT_ACTIVE_INIT;
            state.pin_oe_n <= ~RESET_OUT_ACTIVE_INIT;
            state.active <= RESET_OUT_ACTIVE_INIT;
            state.scl_s1 <= 1'b1;
            state.scl_s2 <= 1'b1;
            state.sda_s1 <= 1'b1;
            state.sda_s2 <= 1'b1;
            state.sda_prev <= 1'b1;
        end
        else
            state <= next_state;
    end

    assign reset_pin_out = 1'b0;
    assign reset_pin_oe_n = state.pin_oe_n;
    assign reset_active = state.active;
    assign bus_enabled = state.enabled;
    assign transaction_open = state.open;
    assign transaction_abort = state.abort;
    assign program_busy = state.busy;
    assign program_start = state.start;
endmodule : ssrs_supervisor

// ==== tb/ssrs_supervisor_asserts.sv ====
// Checker for the supply reset supervisor ports
`timescale 1ns/1ps
module ssrs_supervisor_asserts
    import ssrs_pkg::*;
#(
    parameter int TIMEOUT_CYCLES = 200,
    parameter int PROG_CYCLES = 100
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic supply_low,
    input wire logic reset_pin_in,
    input wire logic reset_pin_out,
    input wire logic reset_pin_oe_n,
    input wire logic reset_active,
    input wire logic bus_enabled,
    input wire logic transaction_open,
    input wire logic transaction_abort,
    input wire logic program_busy,
    input wire logic program_start
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic [TIMER_WIDTH-1:0] act_len;
    logic [TIMER_WIDTH-1:0] busy_len;
    // Lengths of the current active and busy spans
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            act_len <= '0;
            busy_len <= '0;
        end
        else
        begin
            act_len <= reset_active ? act_len + 1'b1 : '0;
            busy_len <= program_busy ? busy_len + 1'b1 : '0;
        end
    end
    property p_pin_data; reset_pin_out == 1'b0; endproperty
    a_pin_data: assert property (p_pin_data) else $error("pin data not low");
    property p_drive; reset_pin_oe_n == !reset_active; endproperty
    a_drive: assert property (p_drive) else $error("pin drive wrong");
    property p_trip; supply_low[*8] ##1 supply_low[*8] |-> ##[0:8] reset_active; endproperty
    a_trip: assert property (p_trip) else $error("no trip");
    property p_dip; !reset_active && $rose(supply_low) ##1 !supply_low |-> !reset_active[*8];
    endproperty
    a_dip: assert property (p_dip) else $error("dip tripped");
    property p_mr; !reset_active && $fell(reset_pin_in) ##1 reset_pin_in |-> !reset_active[*8];
    endproperty
    a_mr: assert property (p_mr) else $error("spike tripped");
    property p_hold; $fell(reset_active) |-> act_len >= TIMEOUT_CYCLES - 1; endproperty
    a_hold: assert property (p_hold) else $error("hold too short");
    property p_bus_off; reset_active || program_busy |-> !bus_enabled; endproperty
    a_bus_off: assert property (p_bus_off) else $error("bus on");
    property p_guard; reset_active ##1 reset_active |-> !transaction_open && !program_start;
    endproperty
    a_guard: assert property (p_guard) else $error("bus in reset");
    property p_abort; transaction_abort |=> !transaction_abort && !transaction_open; endproperty
    a_abort: assert property (p_abort) else $error("bad abort");
    property p_prog_len; $fell(program_busy) |-> busy_len == PROG_CYCLES; endproperty
    a_prog_len: assert property (p_prog_len) else $error("write length");
    property p_keep; program_busy && busy_len < PROG_CYCLES - 1 |=> program_busy; endproperty
    a_keep: assert property (p_keep) else $error("write cut");
    c_write: cover property (program_start);
    c_abort: cover property (transaction_abort);
    c_manual: cover property (!reset_active && $fell(reset_pin_in));
endmodule : ssrs_supervisor_asserts

bind ssrs_supervisor ssrs_supervisor_asserts #(
    .TIMEOUT_CYCLES(TIMEOUT_CYCLES), .PROG_CYCLES(PROG_CYCLES)
) ssrs_supervisor_asserts_inst (
    .clk(clk), .rst_n(rst_n), .supply_low(supply_low), .reset_pin_in(reset_pin_in),
    .reset_pin_out(reset_pin_out), .reset_pin_oe_n(reset_pin_oe_n),
    .reset_active(reset_active), .bus_enabled(bus_enabled),
    .transaction_open(transaction_open), .transaction_abort(transaction_abort),
    .program_busy(program_busy), .program_start(program_start)
);

// ==== tb/ssrs_bus_master.sv ====
// Two-wire bus master model, 80 ns link clock
`timescale 1ns/1ps
module ssrs_bus_master
(
    output logic scl,
    output logic sda
);
    // Idle bus, both lines pulled up
    initial
    begin
        scl = 1'b1;
        sda = 1'b1;
    end
    task automatic start_cond();
        #40 sda = 1'b0;
        #40 scl = 1'b0;
    endtask : start_cond
    task automatic data_bit(input logic b);
        sda = b;
        #40 scl = 1'b1;
        #40 scl = 1'b0;
    endtask : data_bit
    task automatic stop_cond();
        sda = 1'b0;
        #40 scl = 1'b1;
        #40 sda = 1'b1;
    endtask : stop_cond
endmodule : ssrs_bus_master

// ==== tb/ssrs_supervisor_tb.sv ====
// Testbench of the supply reset supervisor
`timescale 1ns/1ps
module ssrs_supervisor_tb;
    localparam int TO = 200;
    localparam int PG = 100;
    typedef struct packed {logic manual; logic [7:0] width; logic act;} ssrs_row_type;
    ssrs_row_type rows [6] = '{'{1'b0, 8'h01, 1'b0}, '{1'b0, 8'h06, 1'b0},
        '{1'b1, 8'h01, 1'b0}, '{1'b1, 8'h0a, 1'b0}, '{1'b0, 8'h28, 1'b1}, '{1'b1, 8'h28, 1'b1}};
    logic clk = 1'b0, rst_n = 1'b0, supply_low = 1'b1, mr_low = 1'b0, write_request = 1'b0;
    logic reset_pin_out, reset_pin_oe_n, reset_active, bus_enabled, transaction_open;
    logic transaction_abort, program_busy, program_start, scl, sda;
    logic saw_start = 1'b0, saw_abort = 1'b0, saw_open = 1'b0;
    int error_cnt = 0, checked = 0, cycles = 0, n, t;
    wire logic reset_pin_in = reset_pin_oe_n & ~mr_low;
    ssrs_supervisor #(.TIMEOUT_CYCLES(TO), .PROG_CYCLES(PG)) ssrs_supervisor_inst (
        .clk(clk), .rst_n(rst_n), .supply_low(supply_low), .reset_pin_in(reset_pin_in),
        .reset_pin_out(reset_pin_out), .reset_pin_oe_n(reset_pin_oe_n),
        .reset_active(reset_active), .scl_in(scl), .sda_in(sda),
        .write_request(write_request), .bus_enabled(bus_enabled),
        .transaction_open(transaction_open), .transaction_abort(transaction_abort),
        .program_busy(program_busy), .program_start(program_start));
    ssrs_bus_master ssrs_bus_master_inst (.scl(scl), .sda(sda));
    always #2 clk = ~clk;
    // Pulses are gathered away from the launching edge
    always @(negedge clk)
    begin
        cycles++;
        saw_start |= program_start;
        saw_abort |= transaction_abort;
        saw_open |= transaction_open;
        if (cycles == 20000)
        begin
            error_cnt++;
            report_and_stop();
        end
    end
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : tick
    task automatic check(input string name, input logic seen, input logic exp);
        checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("MISMATCH %s expected %b seen %b", name, exp, seen);
        end
    endtask : check
    task automatic wait_rel(output int k);
        k = 0;
        while (reset_active !== 1'b0 && k < 2000)
        begin
            tick(1);
            k++;
        end
    endtask : wait_rel
    task automatic frame(input logic wr);
        logic [7:0] sh;
        sh = 8'ha0;
        ssrs_bus_master_inst.start_cond();
        repeat (8)
        begin
            ssrs_bus_master_inst.data_bit(sh[7]);
            sh = sh << 1;
        end
        tick(1);
        write_request = wr;
        tick(1);
        write_request = 1'b0;
        ssrs_bus_master_inst.stop_cond();
    endtask : frame
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : report_and_stop
    initial
    begin
        tick(2);
        rst_n = 1'b1;
        tick(20);
        check("held low", reset_pin_oe_n, 1'b0);
        supply_low = 1'b0;
        wait_rel(n);
        check("powerup", n >= TO && n <= TO + 30, 1'b1);
        check("released", reset_pin_oe_n, 1'b1);
        $display("powerup done");
        foreach (rows[i])
        begin
            // Pin filter must see the released pin high before the next fall
            tick(40);
            if (rows[i].manual)
                mr_low = 1'b1;
            else
                supply_low = 1'b1;
            tick(rows[i].width);
            mr_low = 1'b0;
            supply_low = 1'b0;
            tick(40);
            check("reset_active", reset_active, rows[i].act);
            wait_rel(n);
            t = 40 + n + (rows[i].manual ? int'(rows[i].width) : 0);
            if (rows[i].act)
                check("hold", t >= TO && t <= TO + 40, 1'b1);
            $display("row %0d done", i);
        end
        // Write, then a START while the write cycle runs (master waited for release)
        frame(1'b0);
        tick(4);
        check("no write", saw_start, 1'b0);
        frame(1'b1);
        tick(4);
        check("write started", saw_start, 1'b1);
        check("bus off", bus_enabled, 1'b0);
        saw_open = 1'b0;
        ssrs_bus_master_inst.start_cond();
        tick(4);
        check("start in write", saw_open, 1'b0);
        ssrs_bus_master_inst.stop_cond();
        tick(PG + 10);
        check("bus back", bus_enabled, 1'b1);
        $display("write test done");
        // Supply drop during a write cycle
        frame(1'b1);
        tick(2);
        supply_low = 1'b1;
        tick(30);
        check("write kept", program_busy, 1'b1);
        ssrs_bus_master_inst.start_cond();
        tick(4);
        check("start in reset", transaction_open, 1'b0);
        ssrs_bus_master_inst.stop_cond();
        supply_low = 1'b0;
        wait_rel(n);
        $display("reset in write done");
        // Abort of an open transaction
        ssrs_bus_master_inst.start_cond();
        tick(4);
        check("open", transaction_open, 1'b1);
        supply_low = 1'b1;
        tick(30);
        check("abort", saw_abort, 1'b1);
        check("closed", transaction_open, 1'b0);
        ssrs_bus_master_inst.stop_cond();
        supply_low = 1'b0;
        wait_rel(n);
        $display("abort done");
        // Reset in mid-run
        rst_n = 1'b0;
        tick(1);
        check("oe in reset", reset_pin_oe_n, 1'b0);
        rst_n = 1'b1;
        wait_rel(n);
        check("rerun", n >= TO && n <= TO + 30, 1'b1);
        $display("mid-run reset done");
        report_and_stop();
    end
endmodule : ssrs_supervisor_tb
